// >>> rtl/acr_ctrl.sv
`default_nettype none
// Operation
// - bit0 picks internal or external reference
// - bit1 clear: result per sample-clock falling edge
// - bit1 set: pin is single-conversion start strobe
// - strobe fall holds all inputs, then sequence
// - block ready when results reach trigger level
// - bit2 set powers converter down
// - bus reads and writes work in power down
// - bits3-4 select input channel
// - bits5-6 count differential channels, reset 01
// - bit7 enables autoscan
// - bits8-9 convert fixed test voltage instead
// - test mode keeps block ready off
// - data 0-9 value, upper lines 00 address
// - test codes 00 normal,01 refp,10 mid,11 refm
module acr_ctrl #(
    parameter int TRIG_LEVEL = 4,
    parameter int CONV_CYCLES = 4
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [1:0] ADDR_I,
    input wire logic [9:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [11:0] RDATA_O,
    input wire logic SAMPLE_CLOCK_INPUT_I,
    input wire logic [11:0] CONV_DATA_I,
    output logic EXT_REF_O,
    output logic POWER_DOWN_O,
    output logic HOLD_O,
    output logic [1:0] CHANNEL_O,
    output logic [1:0] TEST_SEL_O,
    output logic RESULT_VALID_O,
    output logic [11:0] RESULT_O,
    output logic BLOCK_READY_OUTPUT_O,
    output logic IRQ_O
);
    acr_pkg::acr_setup_t setup_r;
    acr_pkg::acr_state_t state_r;
    acr_pkg::acr_state_t state_nxt;
    logic sclk_d_r;
    logic fall;
    logic [7:0] cyc_r;
    logic [1:0] seq_r;
    logic [1:0] seq_last;
    logic [1:0] chan_now;
    logic [4:0] count_r;
    logic [11:0] last_r;
    logic [acr_pkg::ST_W-1:0] stat_r;
    logic [acr_pkg::ST_W-1:0] mask_r;
    logic conv_done;
    logic test_on;
    logic block_ev;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // number of inputs in the scan sequence minus one
    function automatic logic [1:0] scan_len(input acr_pkg::acr_setup_t s);
        if (!s.scan)
            return 2'h0;
        if (s.diff_cnt == 2'h2)
            return 2'h1;
        if (s.diff_cnt == 2'h1)
            return (s.chan_sel == 2'h2) ? 2'h2 : 2'h1;
        return s.chan_sel;
    endfunction : scan_len

    // channel converted at step idx of the sequence
    function automatic logic [1:0] step_chan(input acr_pkg::acr_setup_t s,
                                             input logic [1:0] idx);
        if (!s.scan)
            return s.chan_sel;
        if (s.diff_cnt == 2'h2)
            return idx;
        if (s.diff_cnt == 2'h1)
            return (idx == scan_len(s)) ? 2'h1 : idx;
        return idx;
    endfunction : step_chan

    // result word: a fixed test code, or the converter's own output
    function automatic logic [11:0] result_code(input logic [1:0] sel,
                                                input logic [11:0] raw);
        case (sel)
            acr_pkg::TEST_REFP: return acr_pkg::CODE_REFP;
            acr_pkg::TEST_MID: return acr_pkg::CODE_MID;
            acr_pkg::TEST_REFM: return acr_pkg::CODE_REFM;
            default: return raw;
        endcase
    endfunction : result_code

    // decoded setup, scan position and strobe edge
    assign test_on = (setup_r.test_sel != acr_pkg::TEST_NORMAL);
    assign seq_last = scan_len(setup_r);
    assign chan_now = step_chan(setup_r, seq_r);
    assign fall = sclk_d_r & ~SAMPLE_CLOCK_INPUT_I;
    assign conv_done = (state_r == acr_pkg::ST_CONV) && (cyc_r == 8'(CONV_CYCLES - 1));
    assign block_ev = conv_done && !test_on && (count_r == 5'(TRIG_LEVEL - 1));

    // ---------------------------------------------------------------
    // register write port
    // ---------------------------------------------------------------
    // setup register, writable even when powered down
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            setup_r <= acr_pkg::SETUP_RST;
        else if (WR_I && ADDR_I == acr_pkg::ADDR_SETUP)
            setup_r <= WDATA_I;
    end

    // interrupt mask
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            mask_r <= '0;
        else if (WR_I && ADDR_I == acr_pkg::ADDR_MASK)
            mask_r <= WDATA_I[acr_pkg::ST_W-1:0];
    end

    // ---------------------------------------------------------------
    // sample-clock edge detect
    // ---------------------------------------------------------------
    // last pin level; reset low so no false fall follows reset
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= SAMPLE_CLOCK_INPUT_I;
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    // both modes start only from idle; edges during a sequence are ignored
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            acr_pkg::ST_IDLE:
                if (fall && !setup_r.power_down_bit)
                    state_nxt = acr_pkg::ST_CONV;
            acr_pkg::ST_CONV:
                if (conv_done && seq_r == seq_last)
                    state_nxt = acr_pkg::ST_DONE;
            acr_pkg::ST_DONE:
                state_nxt = acr_pkg::ST_IDLE;
            default:
                state_nxt = acr_pkg::ST_IDLE;
        endcase
        if (setup_r.power_down_bit)
            state_nxt = acr_pkg::ST_IDLE;
    end

    // sequencer state
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            state_r <= acr_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // cycle and step counters
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || state_r != acr_pkg::ST_CONV)
        begin
            cyc_r <= '0;
            seq_r <= '0;
        end
        else if (conv_done)
        begin
            cyc_r <= '0;
            seq_r <= seq_r + 2'h1;
        end
        else
            cyc_r <= cyc_r + 8'h1;
    end

    // sample stages held together from the strobe edge to sequence end
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            HOLD_O <= 1'b0;
        else
            HOLD_O <= (state_nxt == acr_pkg::ST_CONV);
    end

    // result capture, test voltages replace the inputs
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            RESULT_VALID_O <= 1'b0;
            RESULT_O <= '0;
            last_r <= '0;
        end
        else
        begin
            RESULT_VALID_O <= conv_done;
            if (conv_done)
            begin
                RESULT_O <= result_code(setup_r.test_sel, CONV_DATA_I);
                last_r <= result_code(setup_r.test_sel, CONV_DATA_I);
            end
        end
    end

    // results counted toward the trigger level
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || test_on)
            count_r <= '0;
        else if (conv_done)
            count_r <= (count_r == 5'(TRIG_LEVEL - 1)) ? 5'h0 : count_r + 5'h1;
    end

    // block ready: one-cycle pulse, never in test mode
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            BLOCK_READY_OUTPUT_O <= 1'b0;
        else
            BLOCK_READY_OUTPUT_O <= block_ev;
    end

    // ---------------------------------------------------------------
    // analog steering outputs
    // ---------------------------------------------------------------
    // steering levels follow the setup one cycle late
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            EXT_REF_O <= 1'b0;
            POWER_DOWN_O <= 1'b0;
            CHANNEL_O <= '0;
            TEST_SEL_O <= '0;
        end
        else
        begin
            EXT_REF_O <= setup_r.ext_ref;
            POWER_DOWN_O <= setup_r.power_down_bit;
            CHANNEL_O <= chan_now;
            TEST_SEL_O <= setup_r.test_sel;
        end
    end

    // ---------------------------------------------------------------
    // status, interrupt and read port
    // ---------------------------------------------------------------
    // sticky status; a new event wins over the read clear
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            stat_r <= '0;
        else
        begin
            if (RD_I && ADDR_I == acr_pkg::ADDR_STATUS)
                stat_r <= {block_ev, conv_done};
            else
                stat_r <= stat_r | {block_ev, conv_done};
        end
    end

    // level interrupt while an unmasked status bit is set
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |(stat_r & mask_r);
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || !RD_I)
            RDATA_O <= '0;
        else
        begin
            case (ADDR_I)
                acr_pkg::ADDR_SETUP: RDATA_O <= {2'h0, setup_r};
                acr_pkg::ADDR_STATUS: RDATA_O <= {10'h0, stat_r};
                acr_pkg::ADDR_MASK: RDATA_O <= {10'h0, mask_r};
                default: RDATA_O <= last_r;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_test_blocks_ready: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $past(test_on) |-> !BLOCK_READY_OUTPUT_O)
        else $error("block ready raised in test mode");
    a_powerdown_idle: assert property (@(posedge CLK_I) disable iff (SRST_I)
        setup_r.power_down_bit |=> state_r == acr_pkg::ST_IDLE)
        else $error("conversion ran while powered down");
    a_edge_starts: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (state_r == acr_pkg::ST_IDLE && fall && !setup_r.power_down_bit)
        |=> state_r == acr_pkg::ST_CONV)
        else $error("falling edge did not start conversion");
    a_hold_on_edge: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (state_r == acr_pkg::ST_IDLE && fall && !setup_r.power_down_bit)
        |=> HOLD_O)
        else $error("hold not taken on start edge");
    a_setup_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (WR_I && ADDR_I == acr_pkg::ADDR_SETUP) |=> setup_r == $past(WDATA_I))
        else $error("setup write lost");
    a_powerdown_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (WR_I && ADDR_I == acr_pkg::ADDR_MASK && setup_r.power_down_bit)
        |=> mask_r == $past(WDATA_I[1:0]))
        else $error("write refused in power down");
    a_ref_follows: assert property (@(posedge CLK_I) disable iff (SRST_I)
        ##1 EXT_REF_O == $past(setup_r.ext_ref))
        else $error("reference select wrong");
    a_test_code: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (conv_done && setup_r.test_sel == acr_pkg::TEST_MID) |=> RESULT_O == acr_pkg::CODE_MID)
        else $error("midpoint code wrong");
    a_refp_code: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (conv_done && setup_r.test_sel == acr_pkg::TEST_REFP)
        |=> RESULT_O == acr_pkg::CODE_REFP)
        else $error("positive reference code wrong");
    a_result_pulse: assert property (@(posedge CLK_I) disable iff (SRST_I)
        conv_done |=> RESULT_VALID_O)
        else $error("result pulse missing");
    a_status_sticky: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (stat_r[acr_pkg::ST_BLOCK] && !(RD_I && ADDR_I == acr_pkg::ADDR_STATUS))
        |=> stat_r[acr_pkg::ST_BLOCK])
        else $error("block status lost before read");
    a_chan_single: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !setup_r.scan |=> CHANNEL_O == $past(setup_r.chan_sel))
        else $error("channel select not applied");
    a_result_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (RD_I && ADDR_I == acr_pkg::ADDR_RESULT) |=> RDATA_O == $past(last_r))
        else $error("result readback wrong");
endmodule : acr_ctrl
`default_nettype wire

// >>> rtl/acr_pkg.sv
`default_nettype none
package acr_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [1:0] ADDR_SETUP = 2'h0; // conversion_setup, data lines 10..11 = 00
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_MASK = 2'h2;
    localparam logic [1:0] ADDR_RESULT = 2'h3;
    localparam int REG_W = 10;
    localparam int DATA_W = 12;
    localparam logic [9:0] SETUP_RST = 10'h020; // diff count low resets to 1
    // ---------------------------------------------------------------
    // conversion_setup field positions
    // ---------------------------------------------------------------
    localparam int B_VREF = 0;
    localparam int B_MODE = 1;
    localparam int B_POWER_DOWN = 2;
    localparam int B_CHSEL = 3;
    localparam int B_DIFF = 5;
    localparam int B_SCAN = 7;
    localparam int B_TEST = 8;
    // ---------------------------------------------------------------
    // test field encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] TEST_NORMAL = 2'h0;
    localparam logic [1:0] TEST_REFP = 2'h1;
    localparam logic [1:0] TEST_MID = 2'h2;
    localparam logic [1:0] TEST_REFM = 2'h3;
    localparam logic [11:0] CODE_REFP = 12'hfff;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] CODE_REFM = 12'h000;
    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int ST_RESULT = 0;
    localparam int ST_BLOCK = 1;
    localparam int ST_W = 2;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] test_sel;
        logic scan;
        logic [1:0] diff_cnt;
        logic [1:0] chan_sel;
        logic power_down_bit;
        logic single_mode;
        logic ext_ref;
    } acr_setup_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } acr_state_t;
endpackage : acr_pkg
`default_nettype wire

// >>> sim/acr_core_model.sv
`default_nettype none
// converter core and host strobe driver beside the control block
module acr_core_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] channel_i,
    output logic sample_clk_o,
    output logic [11:0] conv_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobe idles high and drops for one cycle per request
    always @(posedge clk_i)
    begin
        sample_clk_o <= !go_i;
    end
    // each channel gives its own code so scan order shows
    assign conv_data_o = 12'h5a0 | {10'h000, channel_i};
    initial sample_clk_o = 1'b1;
endmodule : acr_core_model
`default_nettype wire

// >>> sim/tb_acr_ctrl.sv
`default_nettype none
module tb_acr_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, wr = 0, rd = 0, go = 0, scl;
    logic [1:0] addr = 2'h0;
    logic [9:0] wdata = 10'h000;
    logic [11:0] rdata, cdata, res, v, e;
    logic ext_ref, pwr_dn, hold, rv, blk, irq;
    logic [1:0] chan, tsel;
    int num_errors = 0, cmp_count = 0, nres, nblk, nhold, t, nsum;
    always #50 clk = !clk;
    acr_ctrl #(.TRIG_LEVEL(4), .CONV_CYCLES(4)) dut (.CLK_I(clk), .SRST_I(srst),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .SAMPLE_CLOCK_INPUT_I(scl), .CONV_DATA_I(cdata), .EXT_REF_O(ext_ref),
        .POWER_DOWN_O(pwr_dn), .HOLD_O(hold), .CHANNEL_O(chan), .TEST_SEL_O(tsel),
        .RESULT_VALID_O(rv), .RESULT_O(res), .BLOCK_READY_OUTPUT_O(blk), .IRQ_O(irq));
    acr_core_model core (.clk_i(clk), .go_i(go), .channel_i(chan),
        .sample_clk_o(scl), .conv_data_o(cdata));
    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rst();
        @(posedge clk);
        srst <= 1'b1;
        repeat (15) @(posedge clk);
        srst <= 1'b0;
    endtask : rst
    task automatic wr_reg(input logic [1:0] a, input logic [9:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [11:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // one strobe, then count results, block pulses and hold cycles
    task automatic conv();
        nres = 0;
        nblk = 0;
        nhold = 0;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (40)
        begin
            @(posedge clk);
            #1;
            if (rv === 1'b1) nres++;
            if (blk === 1'b1) nblk++;
            if (hold === 1'b1) nhold++;
        end
    endtask : conv
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_regs();
        rd_reg(acr_pkg::ADDR_SETUP, v);
        chk(v, 12'h020);
        chk({10'h000, ext_ref, pwr_dn}, 12'h000);
        wr_reg(acr_pkg::ADDR_SETUP, 10'h019);
        wr_reg(acr_pkg::ADDR_RESULT, 10'h3ff);
        rd_reg(acr_pkg::ADDR_SETUP, v);
        chk(v, 12'h019);
        chk({11'h000, ext_ref}, 12'h001);
        $display("test regs done");
    endtask : t_regs
    task automatic t_conv();
        wr_reg(acr_pkg::ADDR_SETUP, 10'h010);
        conv();
        chk(nres[11:0], 12'h001);
        chk(res, 12'h5a2);
        chk(nhold[11:0], 12'h004);
        wr_reg(acr_pkg::ADDR_SETUP, 10'h08a);
        conv();
        chk(nres[11:0], 12'h002);
        chk(res, 12'h5a1);
        chk(nhold[11:0], 12'h008);
        wr_reg(acr_pkg::ADDR_SETUP, 10'h006);
        conv();
        chk(nres[11:0], 12'h000);
        chk({11'h000, pwr_dn}, 12'h001);
        wr_reg(acr_pkg::ADDR_MASK, 10'h001);
        rd_reg(acr_pkg::ADDR_MASK, v);
        chk(v, 12'h001);
        rd_reg(acr_pkg::ADDR_RESULT, v);
        chk(v, 12'h5a1);
        $display("test conversion done");
    endtask : t_conv
    task automatic t_block();
        rst();
        wr_reg(acr_pkg::ADDR_SETUP, 10'h002);
        wr_reg(acr_pkg::ADDR_MASK, 10'h002);
        rd_reg(acr_pkg::ADDR_STATUS, v);
        for (t = 1; t <= 4; t++)
        begin
            conv();
            chk(nblk[11:0], (t == 4) ? 12'h001 : 12'h000);
        end
        chk({11'h000, irq}, 12'h001);
        rd_reg(acr_pkg::ADDR_STATUS, v);
        chk(v, 12'h003);
        rd_reg(acr_pkg::ADDR_STATUS, v);
        chk(v, 12'h000);
        #1 chk({11'h000, irq}, 12'h000);
        $display("test block done");
    endtask : t_block
    task automatic t_test();
        rst();
        nsum = 0;
        for (t = 1; t <= 4; t++)
        begin
            wr_reg(acr_pkg::ADDR_SETUP, {t[1:0] | {1'b0, t == 4}, 8'h00});
            conv();
            nsum += nblk;
            chk(nblk[11:0], 12'h000);
            v = (t == 2) ? acr_pkg::CODE_MID : (t == 3) ? acr_pkg::CODE_REFM
                : acr_pkg::CODE_REFP;
            chk(res, v);
            chk({10'h000, tsel}, {10'h000, t[1:0] | {1'b0, t == 4}});
            rd_reg(acr_pkg::ADDR_RESULT, e);
            chk(e, v);
        end
        chk(nsum[11:0], 12'h000);
        rst();
        wr_reg(acr_pkg::ADDR_SETUP, 10'h000);
        conv();
        chk(res, 12'h5a0);
        $display("test mode done");
    endtask : t_test
    initial
    begin
        rst();
        t_regs();
        t_conv();
        t_block();
        t_test();
        conclude();
    end
    // watchdog well past the roughly 600 cycles the tests need
    initial
    begin
        #2000000;
        num_errors++;
        conclude();
    end
endmodule : tb_acr_ctrl
`default_nettype wire
